// *** logic/flag_bank_pkg.sv ***
// constants shared by the peripheral request flag bank
package flag_bank_pkg;

  // ------------------------------------------------------------
  // register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [11:0] DMA1_ADC_IDX        = 12'h4b5;
  localparam logic [11:0] TIMER_SPI1_IDX      = 12'h4b6;
  localparam logic [11:0] PWM1_TIMER3_UART1_IDX = 12'h4b7;
  localparam logic [11:0] PWM2_SPI2_IDX       = 12'h4b8;
  localparam logic [11:0] FLAG_ENABLE_IDX     = 12'h4c0;
  localparam logic [11:0] BANK_STATUS_IDX     = 12'h4c8;
  localparam logic [11:0] BANK_CLEAR_IDX      = 12'h4c9;
  localparam logic [11:0] BANK_ENABLE_IDX     = 12'h4ca;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W        = 14;
  localparam int unsigned REG_COUNT     = 4;
  localparam int unsigned PERIPH_REG_W  = 8;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [31:0] BANK_RESET    = 32'h0000_0000;
  localparam logic [3:0]  STATUS_RESET  = 4'h0;

  // ------------------------------------------------------------
  // bit positions inside each byte-wide request register
  // ------------------------------------------------------------
  localparam int DMA_CH1_ABORT_POS    = 7;
  localparam int DMA_CH1_OVERRUN_POS  = 6;
  localparam int DMA_CH1_DEST_POS     = 5;
  localparam int DMA_CH1_SRC_POS      = 4;
  localparam int ADC_THRESHOLD_POS    = 0;
  localparam int TIMER0_POS           = 7;
  localparam int CAPCOMP1_POS         = 6;
  localparam int TIMER1_GATE_POS      = 5;
  localparam int TIMER1_POS           = 4;
  localparam int TIMER2_POS           = 3;
  localparam int SPI1_SUMMARY_POS     = 2;
  localparam int SPI1_TRANSMIT_POS    = 1;
  localparam int SPI1_RECEIVE_POS     = 0;
  localparam int PWM1_PARAMETER_POS   = 7;
  localparam int PWM1_PERIOD_POS      = 6;
  localparam int TIMER3_GATE_POS      = 5;
  localparam int TIMER3_POS           = 4;
  localparam int UART1_SUMMARY_POS    = 3;
  localparam int UART1_ERROR_POS      = 2;
  localparam int UART1_TRANSMIT_POS   = 1;
  localparam int UART1_RECEIVE_POS    = 0;
  localparam int PWM2_PARAMETER_POS   = 7;
  localparam int PWM2_PERIOD_POS      = 6;
  localparam int LOGIC_CELL2_POS      = 5;
  localparam int COMPARATOR2_POS      = 4;
  localparam int SPI2_SUMMARY_POS     = 2;
  localparam int SPI2_TRANSMIT_POS    = 1;
  localparam int SPI2_RECEIVE_POS     = 0;

  // ------------------------------------------------------------
  // access masks, byte k of the bank is request register k
  // ------------------------------------------------------------
  localparam logic [31:0] HS_MASK = 32'h70_70_f8_f1;
  localparam logic [31:0] RO_MASK = 32'h87_8f_07_00;

endpackage

// *** logic/sticky_flag_bank.sv ***
// sticky hardware-set, software-writable request flags
`timescale 1ns/1ps
module sticky_flag_bank (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [31:0] set_pulse,
  input  wire logic [3:0]  wr_lane,
  input  wire logic [7:0]  wr_byte,
  output logic      [31:0] flags
);

  typedef struct packed
  {
    logic [31:0] flag;
  } bank_t;

  bank_t       s_q;
  bank_t       s_d;
  logic [31:0] lane_mask;

  // ------------------------------------------------------------
  // byte lane expansion
  // ------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_lane
      assign lane_mask[8*k +: 8] = {8{wr_lane[k]}};
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // set wins over a software write of zero, so no event is lost
  always_comb
  begin
    s_d.flag = (lane_mask & {4{wr_byte}}) | (~lane_mask & s_q.flag); // [RL3]
    s_d.flag = (s_d.flag | set_pulse) & flag_bank_pkg::HS_MASK;     // [RL1]
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      s_q.flag <= flag_bank_pkg::BANK_RESET; // [RL4]
    else
      s_q <= s_d;
  end

  assign flags = s_q.flag;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sticky_hold_a : assert property (@(posedge mclk) disable iff (rst) // [RL3]
    (wr_lane == 4'h0) |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag cleared without a software write");

endmodule

// *** logic/peripheral_interrupt_flag_bank.sv ***
// peripheral interrupt request flag bank with avalon-mm register access
//
// Overview of operation
// [RL1] flags set on event regardless of enables
// [RL2] software clears flag before enabling interrupt
// [RL3] set flag holds until software clears it
// [RL4] all flags reset to zero
// [RL5] dma channel1 flags at bits 7..4
// [RL6] adc threshold flag at bit 0
// [RL7] timer/spi1 register layout, bits 7..0
// [RL8] spi1 summary mirrors any bit pending
// [RL9] spi1 transmit/receive read-only mirrors
// [RL10] pwm1/timer3/uart1 register layout, bits 7..0
// [RL11] pwm1 parameter flag follows its register
// [RL12] uart1 summary follows its event register
// [RL13] uart1 error follows its error register
// [RL14] uart1 transmit/receive read-only mirrors
// [RL15] pwm2/spi2 register layout, bit 3 empty
// [RL16] flag and enable forward pending request
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module peripheral_interrupt_flag_bank (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dma_ch1_abort_event,
  input  wire logic        dma_ch1_overrun_event,
  input  wire logic        dma_ch1_dest_count_event,
  input  wire logic        dma_ch1_src_count_event,
  input  wire logic        adc_threshold_event,
  input  wire logic        timer0_event,
  input  wire logic        capcomp1_event,
  input  wire logic        timer1_gate_event,
  input  wire logic        timer1_event,
  input  wire logic        timer2_event,
  input  wire logic        pwm_unit1_period_event,
  input  wire logic        timer3_gate_event,
  input  wire logic        timer3_event,
  input  wire logic        pwm_unit2_period_event,
  input  wire logic        logic_cell2_event,
  input  wire logic        comparator2_event,
  input  wire logic [7:0]  spi_port1_event_register,
  input  wire logic        spi_port1_transmit_state,
  input  wire logic        spi_port1_receive_state,
  input  wire logic [7:0]  pwm_unit1_event_register,
  input  wire logic [7:0]  serial_port1_event_register,
  input  wire logic [7:0]  serial_port1_error_register,
  input  wire logic        serial_port1_transmit_state,
  input  wire logic        serial_port1_receive_state,
  input  wire logic [7:0]  pwm_unit2_event_register,
  input  wire logic [7:0]  spi_port2_event_register,
  input  wire logic        spi_port2_transmit_state,
  input  wire logic        spi_port2_receive_state,
  output logic      [31:0] pending_request,
  output logic             irq
);

  // ------------------------------------------------------------
  // addresses
  // ------------------------------------------------------------
  localparam logic [13:0] DMA1_ADC_ADDR   = {flag_bank_pkg::DMA1_ADC_IDX, 2'b00};
  localparam logic [13:0] TIMER_SPI1_ADDR = {flag_bank_pkg::TIMER_SPI1_IDX, 2'b00};
  localparam logic [13:0] PWM1_ADDR       = {flag_bank_pkg::PWM1_TIMER3_UART1_IDX, 2'b00};
  localparam logic [13:0] PWM2_ADDR       = {flag_bank_pkg::PWM2_SPI2_IDX, 2'b00};
  localparam logic [13:0] FLAG_EN_ADDR    = {flag_bank_pkg::FLAG_ENABLE_IDX, 2'b00};
  localparam logic [13:0] STATUS_ADDR     = {flag_bank_pkg::BANK_STATUS_IDX, 2'b00};
  localparam logic [13:0] CLEAR_ADDR      = {flag_bank_pkg::BANK_CLEAR_IDX, 2'b00};
  localparam logic [13:0] STATUS_EN_ADDR  = {flag_bank_pkg::BANK_ENABLE_IDX, 2'b00};

  typedef struct packed
  {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] ro;
    logic [31:0] prev;
    logic [31:0] flag_en;
    logic [3:0]  status;
    logic [3:0]  status_en;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic        req;
  logic        commit_wr;
  logic [3:0]  flag_lane;
  logic [31:0] set_vec;
  logic [31:0] hs_flags;
  logic [31:0] combined;
  logic [3:0]  reg_event;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // one wait state; the write lands at the edge where waitrequest is low
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~s_q.ack;
  assign commit_wr       = avs_write & s_q.ack & avs_byteenable[0];

  // ------------------------------------------------------------
  // event vector into the sticky bank
  // ------------------------------------------------------------
  always_comb
  begin
    set_vec = flag_bank_pkg::BANK_RESET;
    set_vec[flag_bank_pkg::DMA_CH1_ABORT_POS]        = dma_ch1_abort_event;      // [RL5]
    set_vec[flag_bank_pkg::DMA_CH1_OVERRUN_POS]      = dma_ch1_overrun_event;    // [RL5]
    set_vec[flag_bank_pkg::DMA_CH1_DEST_POS]         = dma_ch1_dest_count_event; // [RL5]
    set_vec[flag_bank_pkg::DMA_CH1_SRC_POS]          = dma_ch1_src_count_event;  // [RL5]
    set_vec[flag_bank_pkg::ADC_THRESHOLD_POS]        = adc_threshold_event;      // [RL6]
    set_vec[8 + flag_bank_pkg::TIMER0_POS]           = timer0_event;             // [RL7]
    set_vec[8 + flag_bank_pkg::CAPCOMP1_POS]         = capcomp1_event;           // [RL7]
    set_vec[8 + flag_bank_pkg::TIMER1_GATE_POS]      = timer1_gate_event;        // [RL7]
    set_vec[8 + flag_bank_pkg::TIMER1_POS]           = timer1_event;             // [RL7]
    set_vec[8 + flag_bank_pkg::TIMER2_POS]           = timer2_event;             // [RL7]
    set_vec[16 + flag_bank_pkg::PWM1_PERIOD_POS]     = pwm_unit1_period_event;   // [RL10]
    set_vec[16 + flag_bank_pkg::TIMER3_GATE_POS]     = timer3_gate_event;        // [RL10]
    set_vec[16 + flag_bank_pkg::TIMER3_POS]          = timer3_event;             // [RL10]
    set_vec[24 + flag_bank_pkg::PWM2_PERIOD_POS]     = pwm_unit2_period_event;   // [RL15]
    set_vec[24 + flag_bank_pkg::LOGIC_CELL2_POS]     = logic_cell2_event;        // [RL15]
    set_vec[24 + flag_bank_pkg::COMPARATOR2_POS]     = comparator2_event;        // [RL15]
  end

  assign flag_lane[0] = commit_wr & (avs_address == DMA1_ADC_ADDR);
  assign flag_lane[1] = commit_wr & (avs_address == TIMER_SPI1_ADDR);
  assign flag_lane[2] = commit_wr & (avs_address == PWM1_ADDR);
  assign flag_lane[3] = commit_wr & (avs_address == PWM2_ADDR);

  // flags are set by events and by software writes; enables only gate the forwarded request
  sticky_flag_bank u_flags (
    .mclk      (mclk),
    .rst       (rst),
    .set_pulse (set_vec),
    .wr_lane   (flag_lane),
    .wr_byte   (avs_writedata[7:0]),
    .flags     (hs_flags)
  ); // [RL1]

  // read-only bits can never be written, the bank masks them out
  assign combined = hs_flags | (s_q.ro & flag_bank_pkg::RO_MASK); // [RL9]

  genvar r;
  generate
    for (r = 0; r < 4; r++)
    begin : g_event
      assign reg_event[r] = |(combined[8*r +: 8] & ~s_q.prev[8*r +: 8]);
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d      = s_q;
    s_d.ack  = avs_waitrequest;
    s_d.prev = combined;

    // mirrored and summary bits follow the peripheral one cycle late
    s_d.ro = flag_bank_pkg::BANK_RESET;
    s_d.ro[8 + flag_bank_pkg::SPI1_SUMMARY_POS]    = |spi_port1_event_register;    // [RL8]
    s_d.ro[8 + flag_bank_pkg::SPI1_TRANSMIT_POS]   = spi_port1_transmit_state;     // [RL9]
    s_d.ro[8 + flag_bank_pkg::SPI1_RECEIVE_POS]    = spi_port1_receive_state;      // [RL9]
    s_d.ro[16 + flag_bank_pkg::PWM1_PARAMETER_POS] = |pwm_unit1_event_register;    // [RL11]
    s_d.ro[16 + flag_bank_pkg::UART1_SUMMARY_POS]  = |serial_port1_event_register; // [RL12]
    s_d.ro[16 + flag_bank_pkg::UART1_ERROR_POS]    = |serial_port1_error_register; // [RL13]
    s_d.ro[16 + flag_bank_pkg::UART1_TRANSMIT_POS] = serial_port1_transmit_state;  // [RL14]
    s_d.ro[16 + flag_bank_pkg::UART1_RECEIVE_POS]  = serial_port1_receive_state;   // [RL14]
    s_d.ro[24 + flag_bank_pkg::PWM2_PARAMETER_POS] = |pwm_unit2_event_register;    // [RL15]
    s_d.ro[24 + flag_bank_pkg::SPI2_SUMMARY_POS]   = |spi_port2_event_register;    // [RL15]
    s_d.ro[24 + flag_bank_pkg::SPI2_TRANSMIT_POS]  = spi_port2_transmit_state;     // [RL15]
    s_d.ro[24 + flag_bank_pkg::SPI2_RECEIVE_POS]   = spi_port2_receive_state;      // [RL15]

    // read data captured in the wait cycle, held until the next read
    if (avs_read & avs_waitrequest)
    begin
      case (avs_address)
        DMA1_ADC_ADDR:   s_d.rdata = {24'h00_0000, combined[7:0]};   // [RL5]
        TIMER_SPI1_ADDR: s_d.rdata = {24'h00_0000, combined[15:8]};  // [RL7]
        PWM1_ADDR:       s_d.rdata = {24'h00_0000, combined[23:16]}; // [RL10]
        PWM2_ADDR:       s_d.rdata = {24'h00_0000, combined[31:24]}; // [RL15]
        FLAG_EN_ADDR:    s_d.rdata = s_q.flag_en;
        STATUS_ADDR:     s_d.rdata = {28'h000_0000, s_q.status};
        STATUS_EN_ADDR:  s_d.rdata = {28'h000_0000, s_q.status_en};
        default:         s_d.rdata = flag_bank_pkg::BANK_RESET;
      endcase
    end

    // enable writes honour every byte lane
    if (avs_write & s_q.ack & (avs_address == FLAG_EN_ADDR))
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (avs_byteenable[b])
          s_d.flag_en[8*b +: 8] = avs_writedata[8*b +: 8];
      end
    end
    if (commit_wr & (avs_address == STATUS_EN_ADDR))
      s_d.status_en = avs_writedata[3:0];

    // a new event in the clearing cycle keeps its status bit
    if (commit_wr & (avs_address == CLEAR_ADDR))
      s_d.status = s_q.status & ~avs_writedata[3:0];
    s_d.status = s_d.status | reg_event;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q.ack       <= 1'b0;
      s_q.rdata     <= flag_bank_pkg::BANK_RESET;
      s_q.ro        <= flag_bank_pkg::BANK_RESET; // [RL4]
      s_q.prev      <= flag_bank_pkg::BANK_RESET;
      s_q.flag_en   <= flag_bank_pkg::BANK_RESET;
      s_q.status    <= flag_bank_pkg::STATUS_RESET;
      s_q.status_en <= flag_bank_pkg::STATUS_RESET;
    end
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // software is expected to clear a stale flag before it sets the enable
  assign pending_request = combined & s_q.flag_en; // [RL16] [RL2]
  assign irq             = |(s_q.status & s_q.status_en);
  assign avs_readdata    = s_q.rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence bus_wait_s;
    req && avs_waitrequest;
  endsequence

  sequence bus_done_s;
    req && !avs_waitrequest;
  endsequence

  bus_answer_a : assert property (bus_wait_s |=> bus_done_s)
    else $error("bus answer not one cycle after request");

  event_sets_flag_a : assert property (timer0_event |=> hs_flags[15]) // [RL1]
    else $error("timer0 event did not set its flag");

  reset_clears_a : assert property (disable iff (1'b0) rst |=> (combined == 32'h0000_0000)) // [RL4]
    else $error("flags not zero after reset");

  dma_layout_a : assert property (dma_ch1_dest_count_event |=> hs_flags[5]) // [RL5]
    else $error("dma destination count flag not at bit 5");

  adc_hold_a : assert property ((hs_flags[0] && !flag_lane[0]) |=> hs_flags[0]) // [RL6]
    else $error("adc threshold flag dropped by hardware");

  timer_read_a : assert property ((bus_wait_s ##1 bus_done_s) and // [RL7]
    (avs_read && avs_address == TIMER_SPI1_ADDR)[*2]
    |-> avs_readdata == {24'h00_0000, $past(combined[15:8])})
    else $error("timer/spi1 read data wrong");

  spi1_summary_a : assert property (##1 combined[10] == |$past(spi_port1_event_register)) // [RL8]
    else $error("spi1 summary does not follow its register");

  pwm1_layout_a : assert property (pwm_unit1_period_event |=> combined[22]) // [RL10]
    else $error("pwm1 period flag not at bit 6");

  uart_mirror_a : assert property ((flag_lane[2] && serial_port1_error_register == 8'h00 && // [RL13]
    !serial_port1_transmit_state) |=> !combined[18] && !combined[17])
    else $error("uart1 read-only bits disturbed by a write");

  unused_bits_a : assert property ((combined[27] | combined[3:1]) == 1'b0) // [RL15]
    else $error("unimplemented flag bit reads one");

  pending_a : assert property ((timer3_event && s_q.flag_en[20]) |=> pending_request[20]) // [RL16]
    else $error("enabled flag not forwarded as pending");

  // every hardware-set bit, not only the timer0 one
  genvar f;
  generate
    for (f = 0; f < 32; f++)
    begin : g_set_chk
      if (flag_bank_pkg::HS_MASK[f])
      begin : g_hs
        flag_set_a : assert property (set_vec[f] |=> hs_flags[f]) // [RL1]
          else $error("event did not set its flag");
      end
    end
  endgenerate

  flag_zero_a : assert property ((flag_lane[1] && avs_writedata[7:0] == 8'h00 && set_vec[15:8] == 8'h00) // [RL3]
    |=> hs_flags[15:8] == 8'h00)
    else $error("software clear of a flag register lost");

  // mirrors lag their inputs by one cycle
  pwm1_param_a : assert property (!rst |=> combined[23] == |$past(pwm_unit1_event_register)) // [RL11]
    else $error("pwm1 parameter flag wrong");

  uart_summary_a : assert property (!rst |=> combined[19] == |$past(serial_port1_event_register)) // [RL12]
    else $error("uart1 summary flag wrong");

  uart_error_a : assert property (!rst |=> combined[18] == |$past(serial_port1_error_register)) // [RL13]
    else $error("uart1 error flag wrong");

  uart_txrx_a : assert property (!rst |=> combined[17:16] == // [RL14]
    {$past(serial_port1_transmit_state), $past(serial_port1_receive_state)})
    else $error("uart1 mirror wrong");

  spi1_txrx_a : assert property (!rst |=> combined[9:8] == // [RL9]
    {$past(spi_port1_transmit_state), $past(spi_port1_receive_state)})
    else $error("spi1 mirror wrong");

  pwm2_param_a : assert property (!rst |=> combined[31] == |$past(pwm_unit2_event_register)) // [RL15]
    else $error("pwm2 parameter flag wrong");

  spi2_mirror_a : assert property (!rst |=> combined[26:24] == // [RL15]
    {|$past(spi_port2_event_register), $past(spi_port2_transmit_state), $past(spi_port2_receive_state)})
    else $error("spi2 mirrors wrong");

  sequence clear_bit0_s;
    commit_wr && (avs_address == CLEAR_ADDR) && avs_writedata[0] && !reg_event[0];
  endsequence

  // a flag rising in the clearing cycle keeps its status bit
  generate
    for (f = 0; f < 4; f++)
    begin : g_status_chk
      status_set_a : assert property (reg_event[f] |=> s_q.status[f])
        else $error("new flag did not set its status bit");
    end
  endgenerate

  status_clear_a : assert property (clear_bit0_s |=> !s_q.status[0])
    else $error("status bit not cleared");

  irq_level_a : assert property ((s_q.status[0] && s_q.status_en[0]) |-> irq)
    else $error("enabled status bit without interrupt");

endmodule

// *** sim/periph_model.sv ***
// partner model: on-chip peripherals raising events and holding their own flag registers
`timescale 1ns/1ps
module periph_model (
  input  wire logic        mclk,
  output logic      [31:0] ev,
  output logic      [53:0] lv
);
  // ------------------------------------------------------------
  // event pulses and level registers
  // ------------------------------------------------------------
  // an event stays up one cycle only; held up it would set the flag again every cycle
  initial
  begin
    ev = '0;
    lv = '0;
  end

  task automatic pulse(input logic [31:0] m);
    ev <= m;
    @(posedge mclk);
    ev <= '0;
  endtask

  // registers and tx/rx states are levels that the peripheral itself clears
  task automatic set_levels(input logic [53:0] v);
    lv <= v;
  endtask
endmodule

// *** sim/peripheral_interrupt_flag_bank_tb_top.sv ***
// self-checking bench for the peripheral request flag bank
`timescale 1ns/1ps
module peripheral_interrupt_flag_bank_tb_top;
  logic        mclk;
  logic        rst;
  logic [13:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] pending_request;
  logic        irq;
  logic [31:0] ev;
  logic [53:0] lv;
  logic [31:0] exp_hs;
  logic [53:0] lv_tb;
  logic [31:0] en;
  logic [31:0] d;
  int          bad_count;
  int          compares;

  periph_model pm (.mclk(mclk), .ev(ev), .lv(lv));

  peripheral_interrupt_flag_bank dut (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dma_ch1_abort_event(ev[7]), .dma_ch1_overrun_event(ev[6]),
    .dma_ch1_dest_count_event(ev[5]), .dma_ch1_src_count_event(ev[4]), .adc_threshold_event(ev[0]),
    .timer0_event(ev[15]), .capcomp1_event(ev[14]), .timer1_gate_event(ev[13]), .timer1_event(ev[12]),
    .timer2_event(ev[11]), .pwm_unit1_period_event(ev[22]), .timer3_gate_event(ev[21]),
    .timer3_event(ev[20]), .pwm_unit2_period_event(ev[30]), .logic_cell2_event(ev[29]),
    .comparator2_event(ev[28]), .spi_port1_event_register(lv[7:0]), .spi_port1_transmit_state(lv[48]),
    .spi_port1_receive_state(lv[49]), .pwm_unit1_event_register(lv[15:8]),
    .serial_port1_event_register(lv[23:16]), .serial_port1_error_register(lv[31:24]),
    .serial_port1_transmit_state(lv[50]), .serial_port1_receive_state(lv[51]),
    .pwm_unit2_event_register(lv[39:32]), .spi_port2_event_register(lv[47:40]),
    .spi_port2_transmit_state(lv[52]), .spi_port2_receive_state(lv[53]),
    .pending_request(pending_request), .irq(irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic [31:0] ro_exp(input logic [53:0] v);
    logic [31:0] r;
    r = '0;
    r[10] = |v[7:0];
    r[9] = v[48];
    r[8] = v[49];
    r[23] = |v[15:8];
    r[19] = |v[23:16];
    r[18] = |v[31:24];
    r[17] = v[50];
    r[16] = v[51];
    r[31] = |v[39:32];
    r[26] = |v[47:40];
    r[25] = v[52];
    r[24] = v[53];
    return r;
  endfunction

  function automatic logic [31:0] reg_now(input int k);
    logic [31:0] a;
    a = exp_hs | ro_exp(lv_tb);
    return {24'h0, a[k*8+:8]};
  endfunction

  function automatic logic [11:0] idx_of(input int k);
    return flag_bank_pkg::DMA1_ADC_IDX + 12'(k);
  endfunction

  // ------------------------------------------------------------
  // report, compare and bus tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e)
    begin
      bad_count++;
      $display("BAD %0t read %h expected %h", $time, got, e);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e)
    begin
      bad_count++;
      $display("BAD %0t output %h expected %h", $time, got, e);
    end
  endtask

  // request held until waitrequest is sampled low; the bound guards against a hang
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] dw, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    avs_address <= {idx, 2'b00};
    avs_writedata <= dw;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 16);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      bad_count++;
      $display("BAD %0t bus answer missing", $time);
      stop_test();
    end
    @(posedge mclk);
  endtask

  task automatic rd_expect(input logic [11:0] idx, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, 4'hf, q);
    chk_val(q, e);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] dw, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, idx, dw, be, q);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    exp_hs = '0;
    lv_tb = '0;
    bad_count = 0;
    compares = 0;
    void'($urandom(32'h59b2));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int k = 0; k < 4; k++) rd_expect(idx_of(k), 32'h0);
    rd_expect(flag_bank_pkg::FLAG_ENABLE_IDX, 32'h0);
    rd_expect(flag_bank_pkg::BANK_STATUS_IDX, 32'h0);
    rd_expect(12'h000, 32'h0);
    $display("reset values done");
    // every hardware event, enables all off
    for (int i = 0; i < 32; i++)
      if (flag_bank_pkg::HS_MASK[i])
      begin
        pm.pulse(32'h1 << i);
        exp_hs[i] = 1'b1;
        repeat (3) @(posedge mclk);
        rd_expect(idx_of(i / 8), reg_now(i / 8));
        chk_pin(32'(irq), 32'h0);
      end
    for (int k = 0; k < 4; k++) rd_expect(idx_of(k), reg_now(k));
    $display("event flags done");
    for (int k = 0; k < 4; k++)
    begin
      wr(idx_of(k), 32'h0, 4'he);
      rd_expect(idx_of(k), reg_now(k));
      wr(idx_of(k), 32'hff, 4'hf);
      rd_expect(idx_of(k), reg_now(k));
      wr(idx_of(k), 32'h0, 4'hf);
      exp_hs[k*8+:8] = 8'h0;
      rd_expect(idx_of(k), reg_now(k));
    end
    $display("software writes done");
    for (int it = 0; it < 12; it++)
    begin
      lv_tb = 54'({$urandom, $urandom});
      for (int k = 0; k < 6; k++) if ($urandom % 2) lv_tb[k*8+:8] = 8'h0;
      if (it == 11) lv_tb = '0;
      pm.set_levels(lv_tb);
      d = $urandom;
      wr(idx_of(it % 4), d, 4'hf);
      exp_hs[(it%4)*8+:8] = d[7:0] & flag_bank_pkg::HS_MASK[(it%4)*8+:8];
      for (int k = 0; k < 4; k++) rd_expect(idx_of(k), reg_now(k));
    end
    $display("peripheral mirrors done");
    fork
      wr(idx_of(0), 32'h0, 4'hf);
      begin
        @(posedge mclk);
        pm.pulse(32'h80);
      end
    join
    exp_hs[7:0] = 8'h80;
    rd_expect(idx_of(0), reg_now(0));
    $display("event against clear done");
    wr(idx_of(0), 32'h0, 4'hf);
    wr(idx_of(2), 32'h0, 4'hf);
    exp_hs[7:0] = 8'h0;
    exp_hs[23:16] = 8'h0;
    wr(flag_bank_pkg::BANK_CLEAR_IDX, 32'hf, 4'hf);
    en = $urandom | 32'h0010_0001;
    wr(flag_bank_pkg::FLAG_ENABLE_IDX, en, 4'hf);
    wr(flag_bank_pkg::BANK_ENABLE_IDX, 32'h1, 4'hf);
    chk_pin(32'(irq), 32'h0);
    chk_pin(pending_request, exp_hs & en);
    pm.pulse(32'h0010_0001);
    exp_hs[0] = 1'b1;
    exp_hs[20] = 1'b1;
    repeat (3) @(posedge mclk);
    chk_pin(pending_request, exp_hs & en);
    chk_pin(32'(irq), 32'h1);
    rd_expect(flag_bank_pkg::BANK_STATUS_IDX, 32'h5);
    wr(flag_bank_pkg::BANK_CLEAR_IDX, 32'h1, 4'hf);
    chk_pin(32'(irq), 32'h0);
    rd_expect(flag_bank_pkg::BANK_STATUS_IDX, 32'h4);
    $display("pending and interrupt done");
    stop_test();
  end
endmodule
